// *** include/buck_regs_pkg.sv ***
// shared constants, types and helpers for the converter register bank
package buck_regs_pkg;
    // register indices on the serial link
    localparam logic [2:0] REG_VOUT1 = 3'h1;
    localparam logic [2:0] REG_VOUT2 = 3'h2;
    localparam logic [2:0] REG_CTRL = 3'h3;
    localparam logic [2:0] REG_STAT = 3'h5;
    // reset values and fixed read answers
    localparam logic [7:0] VOUT_RESET = 8'h64;
    localparam logic [7:0] CTRL_RESET = 8'h6f;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [7:0] STAT_USED_MASK = 8'h19;
    localparam logic [7:0] REG_INDEX_ZERO_MASK = 8'hf8;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // control field positions
    localparam int CTRL_SOFT_RESET = 7;
    localparam int CTRL_FORCED_PULSE_WIDTH_OPERATION_CHANGE = 6;
    localparam int CTRL_ENABLE = 5;
    localparam int CTRL_FORCED_PULSE_WIDTH_OPERATION = 4;
    localparam int CTRL_DISCHARGE = 3;
    localparam int CTRL_RETRY = 2;
    localparam int CTRL_RAMP_HI = 1;
    localparam int CTRL_RAMP_LO = 0;
    // status field positions
    localparam int STAT_THERMAL = 4;
    localparam int STAT_RETRY_SHORT_PROTECTION = 3;
    localparam int STAT_INPUT_UNDERVOLTAGE_LOCKOUT = 0;
    // order of the synchronised event inputs
    localparam int EV_THERMAL = 0;
    localparam int EV_RETRY_SHORT_PROTECTION = 1;
    localparam int EV_INPUT_UNDERVOLTAGE_LOCKOUT = 2;
    // address byte layout
    localparam int ADDR_FIXED_POS = 7;
    localparam int ADDR_DIR_POS = 0;
    localparam logic ADDR_FIXED_VALUE = 1'b1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        link_idle,
        link_addr,
        link_reg,
        link_wdata,
        link_ack,
        link_rdata,
        link_mack
    } link_state_t;

    // a register index byte carries zeros in its upper five bits
    function automatic logic reg_index_valid(input logic [7:0] idx);
        reg_index_valid = (idx & REG_INDEX_ZERO_MASK) == BYTE_ZERO;
    endfunction
endpackage

// *** include/reg_xfer_if.sv ***
// toggle handshake carrying one register access from the link domain to the bank
`timescale 1ns/10ps
`default_nettype none
interface reg_xfer_if;
    logic req_tgl;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic ack_tgl;
    logic [7:0] rdata;
    modport link (output req_tgl, output wr, output addr, output wdata,
                  input ack_tgl, input rdata);
    modport bank (input req_tgl, input wr, input addr, input wdata,
                  output ack_tgl, output rdata);
endinterface
`default_nettype wire

// *** rtl/buck_regulator_i2c_register_bank.sv ***
// top level: register bank of a step-down converter behind its serial slave port
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RULE1 - address byte: one, strap address, direction
// RULE2 - index byte: five zeros, three index bits
// RULE3 - decode targets 1, 2, control 3, status 5
// RULE4 - targets are read/write codes, reset 0x64
// RULE5 - host avoids codes with looser accuracy
// RULE6 - control bit 7 restores every default
// RULE7 - control bit 6 forces pwm while ramping
// RULE8 - control bit 5 disables; setting restarts immediately
// RULE9 - control bit 4 selects light-load pwm
// RULE10 - control bit 3 enables output discharge
// RULE11 - control bit 2 selects retry protection
// RULE12 - control bits 1:0 select ramp rate
// RULE13 - status bit 4 flags thermal warning
// RULE14 - status bit 3 flags retry event
// RULE15 - status bit 0 flags input undervoltage
// RULE16 - flags latch until reset or read
// RULE17 - unmapped index reads as zero
// RULE18 - write lands at ack falling edge
// RULE19 - enable pin falling restores every default
// RULE20 - reserved status bits read zero
module buck_regulator_i2c_register_bank (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic link_clk_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [5:0] addr_select_in,
    input wire logic chip_enable_in,
    input wire logic thermal_warning_in,
    input wire logic retry_event_in,
    input wire logic input_undervoltage_lockout_in,
    output logic [7:0] primary_voltage_code_out,
    output logic [7:0] secondary_voltage_code_out,
    output logic pwm_during_change_out,
    output logic converter_enable_out,
    output logic converter_restart_out,
    output logic forced_pulse_width_operation_out,
    output logic output_discharge_out,
    output logic retry_short_protection_out,
    output logic [1:0] ramp_rate_out
);
    reg_xfer_if xfer ();

    logic en_s1, en_s2, en_s3;
    logic [2:0] ev_s1, ev_s2;
    logic req_s1, req_s2, req_s3;
    logic [7:0] vout1_q, vout2_q;
    logic [6:0] ctrl_q;
    logic [7:0] status_q, status_d;
    logic [7:0] rdata_q, rd_value, ev_bits;
    logic ack_q, restart_q;
    logic req_new, reg_wr, reg_rd, en_fall, soft_reset, regs_clear, stat_read;

    serial_link_slave link_u (
        .link_clk_in(link_clk_in),
        .rst_in(rst_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .addr_select_in(addr_select_in),
        .sda_out(sda_out),
        .sda_oe_out(sda_oe_out),
        .xfer(xfer)
    );

    // pins and the request toggle pass two flip-flops before use
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            en_s1 <= 1'b0;
            en_s2 <= 1'b0;
            en_s3 <= 1'b0;
            ev_s1 <= 3'h0;
            ev_s2 <= 3'h0;
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end else begin
            en_s1 <= chip_enable_in;
            en_s2 <= en_s1;
            en_s3 <= en_s2;
            ev_s1 <= {input_undervoltage_lockout_in, retry_event_in, thermal_warning_in};
            ev_s2 <= ev_s1;
            req_s1 <= xfer.req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end

    assign req_new = req_s2 ^ req_s3;
    assign en_fall = en_s3 & ~en_s2; // RULE19
    assign reg_wr = req_new & xfer.wr & buck_regs_pkg::reg_index_valid(xfer.addr);
    assign reg_rd = req_new & ~xfer.wr;
    assign stat_read = reg_rd & buck_regs_pkg::reg_index_valid(xfer.addr)
        & (xfer.addr[2:0] == buck_regs_pkg::REG_STAT);
    assign soft_reset = reg_wr & (xfer.addr[2:0] == buck_regs_pkg::REG_CTRL)
        & xfer.wdata[buck_regs_pkg::CTRL_SOFT_RESET]; // RULE6
    assign regs_clear = en_fall | soft_reset;

    // settings: a reset source wins over a write in the same cycle
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || regs_clear) begin // RULE6 RULE19
            vout1_q <= buck_regs_pkg::VOUT_RESET; // RULE4
            vout2_q <= buck_regs_pkg::VOUT_RESET;
            ctrl_q <= buck_regs_pkg::CTRL_RESET[6:0];
        end else if (reg_wr) begin // RULE18
            case (xfer.addr[2:0]) // RULE3
                buck_regs_pkg::REG_VOUT1: begin
                    vout1_q <= xfer.wdata; // RULE4
                end
                buck_regs_pkg::REG_VOUT2: begin
                    vout2_q <= xfer.wdata;
                end
                buck_regs_pkg::REG_CTRL: begin
                    ctrl_q <= xfer.wdata[6:0];
                end
                default: begin
                    ctrl_q <= ctrl_q;
                end
            endcase
        end
    end

    // retry events only count while retry protection is selected
    always_comb begin
        ev_bits = buck_regs_pkg::STAT_RESET;
        ev_bits[buck_regs_pkg::STAT_THERMAL] = ev_s2[buck_regs_pkg::EV_THERMAL]; // RULE13
        ev_bits[buck_regs_pkg::STAT_RETRY_SHORT_PROTECTION] = ev_s2[buck_regs_pkg::EV_RETRY_SHORT_PROTECTION]
            & ctrl_q[buck_regs_pkg::CTRL_RETRY]; // RULE14
        ev_bits[buck_regs_pkg::STAT_INPUT_UNDERVOLTAGE_LOCKOUT] = ev_s2[buck_regs_pkg::EV_INPUT_UNDERVOLTAGE_LOCKOUT]; // RULE15
    end

    // an event in the clearing cycle survives the clear
    always_comb begin
        if (regs_clear || stat_read) begin // RULE16
            status_d = ev_bits;
        end else begin
            status_d = status_q | ev_bits;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            status_q <= buck_regs_pkg::STAT_RESET;
        end else begin
            status_q <= status_d & buck_regs_pkg::STAT_USED_MASK; // RULE20
        end
    end

    always_comb begin
        rd_value = buck_regs_pkg::UNMAPPED_READ; // RULE17
        if (buck_regs_pkg::reg_index_valid(xfer.addr)) begin // RULE2
            case (xfer.addr[2:0]) // RULE3
                buck_regs_pkg::REG_VOUT1: rd_value = vout1_q;
                buck_regs_pkg::REG_VOUT2: rd_value = vout2_q;
                buck_regs_pkg::REG_CTRL: rd_value = {1'b0, ctrl_q};
                buck_regs_pkg::REG_STAT: rd_value = status_q;
                default: rd_value = buck_regs_pkg::UNMAPPED_READ;
            endcase
        end
    end

    // every request is answered, writes as well, so the link never waits forever
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ack_q <= 1'b0;
            rdata_q <= buck_regs_pkg::BYTE_ZERO;
        end else if (req_new) begin
            ack_q <= ~ack_q;
            if (!xfer.wr) begin
                rdata_q <= rd_value;
            end
        end
    end

    // restart skips the start-up wait; soft reset also starts anew at once
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= soft_reset | (reg_wr & ~en_fall
                & (xfer.addr[2:0] == buck_regs_pkg::REG_CTRL)
                & xfer.wdata[buck_regs_pkg::CTRL_ENABLE]
                & ~ctrl_q[buck_regs_pkg::CTRL_ENABLE]); // RULE8
        end
    end

    assign xfer.ack_tgl = ack_q;
    assign xfer.rdata = rdata_q;
    assign primary_voltage_code_out = vout1_q;
    assign secondary_voltage_code_out = vout2_q;
    assign pwm_during_change_out = ctrl_q[buck_regs_pkg::CTRL_FORCED_PULSE_WIDTH_OPERATION_CHANGE]; // RULE7
    assign converter_enable_out = ctrl_q[buck_regs_pkg::CTRL_ENABLE]; // RULE8
    assign converter_restart_out = restart_q;
    assign forced_pulse_width_operation_out = ctrl_q[buck_regs_pkg::CTRL_FORCED_PULSE_WIDTH_OPERATION]; // RULE9
    assign output_discharge_out = ctrl_q[buck_regs_pkg::CTRL_DISCHARGE]; // RULE10
    assign retry_short_protection_out = ctrl_q[buck_regs_pkg::CTRL_RETRY]; // RULE11
    assign ramp_rate_out = ctrl_q[buck_regs_pkg::CTRL_RAMP_HI:buck_regs_pkg::CTRL_RAMP_LO]; // RULE12

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    property p_vout_store;
        reg_wr && !en_fall && (xfer.addr[2:0] == buck_regs_pkg::REG_VOUT1)
            |=> (primary_voltage_code_out == $past(xfer.wdata)) ##1 $stable(vout1_q) || req_new;
    endproperty
    a_vout_store: assert property (p_vout_store) else $error("target write lost"); // RULE4

    property p_soft_reset;
        soft_reset |=> (vout1_q == buck_regs_pkg::VOUT_RESET)
            && (vout2_q == buck_regs_pkg::VOUT_RESET)
            && (ctrl_q == buck_regs_pkg::CTRL_RESET[6:0]) && converter_restart_out;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete"); // RULE6

    property p_enable_fall;
        $fell(en_s2) |=> (vout1_q == buck_regs_pkg::VOUT_RESET)
            && (vout2_q == buck_regs_pkg::VOUT_RESET)
            && (ctrl_q == buck_regs_pkg::CTRL_RESET[6:0]);
    endproperty
    a_enable_fall: assert property (p_enable_fall) else $error("enable fall kept values"); // RULE19

    property p_status_hold;
        !regs_clear && !stat_read |=> (status_q & $past(status_q)) == $past(status_q);
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("flag dropped early"); // RULE16

    property p_status_read_clear;
        stat_read && (ev_bits == buck_regs_pkg::STAT_RESET)
            |=> (rdata_q == $past(status_q)) && (status_q == buck_regs_pkg::STAT_RESET);
    endproperty
    a_status_read_clear: assert property (p_status_read_clear) else $error("read kept flags"); // RULE16

    property p_unmapped_zero;
        reg_rd && !buck_regs_pkg::reg_index_valid(xfer.addr)
            |=> rdata_q == buck_regs_pkg::UNMAPPED_READ;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero"); // RULE17

    property p_reserved_zero;
        (status_q & ~buck_regs_pkg::STAT_USED_MASK) == buck_regs_pkg::STAT_RESET;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // RULE20

    property p_thermal_flag;
        ev_s2[buck_regs_pkg::EV_THERMAL] |=> status_q[buck_regs_pkg::STAT_THERMAL];
    endproperty
    a_thermal_flag: assert property (p_thermal_flag) else $error("thermal flag missed"); // RULE13

    property p_input_undervoltage_lockout_flag;
        ev_s2[buck_regs_pkg::EV_INPUT_UNDERVOLTAGE_LOCKOUT] |=> status_q[buck_regs_pkg::STAT_INPUT_UNDERVOLTAGE_LOCKOUT];
    endproperty
    a_input_undervoltage_lockout_flag: assert property (p_input_undervoltage_lockout_flag) else $error("undervoltage flag missed"); // RULE15

    property p_restart_pulse;
        reg_wr && !en_fall && (xfer.addr[2:0] == buck_regs_pkg::REG_CTRL)
            && xfer.wdata[buck_regs_pkg::CTRL_ENABLE] && !ctrl_q[buck_regs_pkg::CTRL_ENABLE]
            |=> converter_restart_out && converter_enable_out ##1 !converter_restart_out;
    endproperty
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart missing"); // RULE8

    property p_disable_keeps;
        reg_wr && !en_fall && (xfer.addr[2:0] == buck_regs_pkg::REG_CTRL)
            && !xfer.wdata[buck_regs_pkg::CTRL_ENABLE]
            && !xfer.wdata[buck_regs_pkg::CTRL_SOFT_RESET]
            |=> !converter_enable_out && $stable(vout1_q) && $stable(vout2_q);
    endproperty
    a_disable_keeps: assert property (p_disable_keeps) else $error("disable lost values"); // RULE8

    c_soft_reset: cover property (soft_reset);
    c_status_read: cover property (stat_read && (status_q != buck_regs_pkg::STAT_RESET));
    c_enable_fall: cover property (en_fall);
    c_vout_write: cover property (reg_wr && (xfer.addr[2:0] == buck_regs_pkg::REG_VOUT2));
endmodule
`default_nettype wire

// *** rtl/serial_link_slave.sv ***
// serial slave front end running on the link clock, oversampling scl and sda
`timescale 1ns/10ps
`default_nettype none
module serial_link_slave (
    input wire logic link_clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [5:0] addr_select_in,
    output logic sda_out,
    output logic sda_oe_out,
    reg_xfer_if.link xfer
);
    logic rst_s1, link_rst;
    logic [2:0] scl_q, sda_q;
    logic [5:0] sel_s1, sel_s2;
    logic ack_s1, ack_s2, ack_s3;
    logic scl_rise, scl_fall, start, stop, ack_new;
    buck_regs_pkg::link_state_t state_q, next_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q, ptr_q, rd_q, wdata_q;
    logic oe_q, wr_pend_q, req_q, wr_q;

    function automatic logic addr_match(input logic [7:0] b, input logic [5:0] sel);
        addr_match = (b[buck_regs_pkg::ADDR_FIXED_POS] == buck_regs_pkg::ADDR_FIXED_VALUE)
            && (b[6:1] == sel);
    endfunction

    // reset and pins enter the link domain through two flip-flops
    always_ff @(posedge link_clk_in) begin
        rst_s1 <= rst_in;
        link_rst <= rst_s1;
    end

    always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            sel_s1 <= 6'h00;
            sel_s2 <= 6'h00;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_s3 <= 1'b0;
        end else begin
            scl_q <= {scl_q[1:0], scl_in};
            sda_q <= {sda_q[1:0], sda_in};
            sel_s1 <= addr_select_in;
            sel_s2 <= sel_s1;
            ack_s1 <= xfer.ack_tgl;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
        end
    end

    assign scl_rise = scl_q[1] & ~scl_q[2];
    assign scl_fall = ~scl_q[1] & scl_q[2];
    assign start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    assign stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
    assign ack_new = ack_s2 ^ ack_s3;

    always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
            state_q <= buck_regs_pkg::link_idle;
            next_q <= buck_regs_pkg::link_idle;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            rd_q <= 8'h00;
            wdata_q <= 8'h00;
            oe_q <= 1'b0;
            wr_pend_q <= 1'b0;
            req_q <= 1'b0;
            wr_q <= 1'b0;
        end else if (start) begin
            state_q <= buck_regs_pkg::link_addr;
            bit_cnt_q <= 4'h0;
            oe_q <= 1'b0;
            wr_pend_q <= 1'b0;
        end else if (stop) begin
            state_q <= buck_regs_pkg::link_idle;
            oe_q <= 1'b0;
            wr_pend_q <= 1'b0;
        end else begin
            if (ack_new) begin
                rd_q <= xfer.rdata;
            end
            case (state_q)
                buck_regs_pkg::link_addr, buck_regs_pkg::link_reg,
                buck_regs_pkg::link_wdata: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_q[1]};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == buck_regs_pkg::BITS_PER_BYTE) begin
                        bit_cnt_q <= 4'h0;
                        state_q <= buck_regs_pkg::link_ack;
                        oe_q <= 1'b1;
                        if (state_q == buck_regs_pkg::link_addr) begin
                            if (!addr_match(shift_q, sel_s2)) begin // RULE1
                                state_q <= buck_regs_pkg::link_idle;
                                oe_q <= 1'b0;
                            end else if (shift_q[buck_regs_pkg::ADDR_DIR_POS]) begin
                                // fetch early so the byte is ready after the ack
                                next_q <= buck_regs_pkg::link_rdata;
                                wr_q <= 1'b0;
                                req_q <= ~req_q;
                            end else begin
                                next_q <= buck_regs_pkg::link_reg;
                            end
                        end else if (state_q == buck_regs_pkg::link_reg) begin
                            ptr_q <= shift_q; // RULE2
                            next_q <= buck_regs_pkg::link_wdata;
                        end else begin
                            wdata_q <= shift_q;
                            wr_pend_q <= 1'b1;
                            next_q <= buck_regs_pkg::link_wdata;
                        end
                    end
                end
                buck_regs_pkg::link_ack: begin
                    if (scl_fall) begin
                        state_q <= next_q;
                        bit_cnt_q <= 4'h0;
                        oe_q <= (next_q == buck_regs_pkg::link_rdata) ? ~rd_q[7] : 1'b0;
                        if (wr_pend_q) begin
                            wr_q <= 1'b1; // RULE18
                            req_q <= ~req_q;
                            wr_pend_q <= 1'b0;
                        end
                    end
                end
                buck_regs_pkg::link_rdata: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == buck_regs_pkg::BITS_PER_BYTE) begin
                        oe_q <= 1'b0;
                        state_q <= buck_regs_pkg::link_mack;
                    end else if (scl_fall) begin
                        rd_q <= {rd_q[6:0], 1'b0};
                        oe_q <= ~rd_q[6];
                    end
                end
                buck_regs_pkg::link_mack: begin
                    // limitation: the next byte is fetched during the master ack
                    if (scl_rise && !sda_q[1]) begin
                        wr_q <= 1'b0;
                        req_q <= ~req_q;
                        next_q <= buck_regs_pkg::link_rdata;
                        state_q <= buck_regs_pkg::link_ack;
                    end else if (scl_rise) begin
                        state_q <= buck_regs_pkg::link_idle;
                    end
                end
                default: begin
                    oe_q <= 1'b0;
                end
            endcase
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = oe_q;
    assign xfer.req_tgl = req_q;
    assign xfer.wr = wr_q;
    assign xfer.addr = ptr_q;
    assign xfer.wdata = wdata_q;

    default clocking @(posedge link_clk_in); endclocking
    default disable iff (link_rst);

    property p_addr_reject;
        (state_q == buck_regs_pkg::link_addr) && scl_fall && !start && !stop
            && (bit_cnt_q == buck_regs_pkg::BITS_PER_BYTE) && !addr_match(shift_q, sel_s2)
            |=> !oe_q && (state_q == buck_regs_pkg::link_idle);
    endproperty
    a_addr_reject: assert property (p_addr_reject) else $error("foreign address acked"); // RULE1

    property p_reg_pointer;
        (state_q == buck_regs_pkg::link_reg) && scl_fall && !start && !stop
            && (bit_cnt_q == buck_regs_pkg::BITS_PER_BYTE)
            |=> (ptr_q == $past(shift_q)) && oe_q;
    endproperty
    a_reg_pointer: assert property (p_reg_pointer) else $error("index byte not taken"); // RULE2

    property p_write_at_ack_fall;
        $changed(req_q) && wr_q |-> ($past(state_q) == buck_regs_pkg::link_ack) && $past(scl_fall);
    endproperty
    a_write_at_ack_fall: assert property (p_write_at_ack_fall) else $error("write off ack"); // RULE18
endmodule
`default_nettype wire

// *** sim/buck_regulator_i2c_register_bank_test.sv ***
// self-checking bench for the converter register bank
`timescale 1ns/10ps
`default_nettype none
module buck_regulator_i2c_register_bank_test;
    localparam logic [5:0] DEV = 6'h2a;
    logic sys_clk_in, link_clk_in, rst_in, scl, host_sda, sda_o, sda_oe, ce, ack;
    logic pchg, en, rs, forced_pulse_width_operation, dis, retry;
    logic [1:0] ramp;
    logic [2:0] ev;
    logic [7:0] v1, v2, rd;
    int n_fail, n_tests, n_rs;
    logic [7:0] idx_t [9] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h00, 8'h04, 8'h06, 8'h07, 8'h09};
    logic [7:0] exp_t [9] = '{8'h64, 8'h64, 8'h6f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // open-drain line with pull-up: low if either side pulls
    wire logic sda = host_sda & (sda_oe ? sda_o : 1'b1);
    wire logic [7:0] ctl = {1'b0, pchg, en, forced_pulse_width_operation, dis, retry, ramp};
    buck_regulator_i2c_register_bank buck_regulator_i2c_register_bank_inst (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .link_clk_in(link_clk_in), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .addr_select_in(DEV),
        .chip_enable_in(ce), .thermal_warning_in(ev[0]), .retry_event_in(ev[1]),
        .input_undervoltage_lockout_in(ev[2]), .primary_voltage_code_out(v1),
        .secondary_voltage_code_out(v2), .pwm_during_change_out(pchg),
        .converter_enable_out(en), .converter_restart_out(rs),
        .forced_pulse_width_operation_out(forced_pulse_width_operation), .output_discharge_out(dis),
        .retry_short_protection_out(retry), .ramp_rate_out(ramp));
    i2c_host_model i2c_host_model_inst (.sda_in(sda), .scl_out(scl), .sda_out(host_sda));
    // restart is a one-cycle pulse; count the cycles it stands high
    always @(negedge sys_clk_in) begin
        if (rs === 1'b1) n_rs++;
    end
    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        link_clk_in = 1'b0;
        #1.3;
        forever #6 link_clk_in = ~link_clk_in;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        i2c_host_model_inst.access(DEV, idx, 1'b1, 8'h00, rd, ack);
        chk(rd, exp);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        i2c_host_model_inst.access(DEV, idx, 1'b0, d, rd, ack);
    endtask
    // events held 8 cycles, above the 3-cycle minimum
    task automatic raise(input logic [2:0] m);
        @(posedge sys_clk_in);
        #1 ev = m;
        repeat (8) @(posedge sys_clk_in);
        #1 ev = 3'b000;
    endtask
    task automatic conclude();
        $display("fail=%0d tests=%0d", n_fail, n_tests);
        if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #380000;
        n_fail++;
        conclude();
    end
    initial begin
        rst_in = 1'b1;
        ce = 1'b1;
        ev = 3'b000;
        repeat (20) @(posedge sys_clk_in);
        #1 rst_in = 1'b0;
        repeat (40) @(posedge sys_clk_in);
        for (int i = 0; i < 9; i++) rd_chk(idx_t[i], exp_t[i]);
        wr(8'h01, 8'ha5);
        chk(v1, 8'ha5);
        rd_chk(8'h01, 8'ha5);
        wr(8'h02, 8'h5a);
        chk(v2, 8'h5a);
        for (int r = 0; r < 4; r++) begin
            wr(8'h03, 8'h10 | 8'(r * 5));
            chk(ctl, 8'h10 | 8'(r * 5));
        end
        rd_chk(8'h03, 8'h1f);
        wr(8'h03, 8'h10);
        raise(3'b010);
        rd_chk(8'h05, 8'h00);
        wr(8'h03, 8'h6f);
        chk(8'(n_rs), 8'h01);
        raise(3'b011);
        rd_chk(8'h05, 8'h18);
        rd_chk(8'h05, 8'h00);
        raise(3'b100);
        rd_chk(8'h05, 8'h01);
        i2c_host_model_inst.access(~DEV, 8'h01, 1'b0, 8'h33, rd, ack);
        chk({7'h00, ack}, 8'h00);
        chk(v1, 8'ha5);
        wr(8'h03, 8'h80);
        chk(v1, 8'h64);
        chk(ctl, 8'h6f);
        chk(8'(n_rs), 8'h02);
        wr(8'h01, 8'ha5);
        @(posedge sys_clk_in);
        #1 ce = 1'b0;
        repeat (10) @(posedge sys_clk_in);
        chk(v1, 8'h64);
        conclude();
    end
endmodule
`default_nettype wire

// *** sim/i2c_host_model.sv ***
// two-wire bus master model that drives the converter's serial port
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    // half bit of 170 ns keeps the device's 12 link-cycle minimum with margin
    localparam int HALF = 170;
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // eight bits and the ack slot, msb first; a 1 only releases the line
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            #(HALF / 2) sda_out = d[i];
            #(HALF / 2) scl_out = 1'b1;
            #(HALF) q[i] = sda_in;
            scl_out = 1'b0;
        end
    endtask
    task automatic start();
        #(HALF / 2) sda_out = 1'b1;
        #(HALF / 2) scl_out = 1'b1;
        #(HALF) sda_out = 1'b0;
        #(HALF) scl_out = 1'b0;
    endtask
    task automatic access(input logic [5:0] dev, input logic [7:0] idx, input logic rd,
                          input logic [7:0] wd, output logic [7:0] rdat, output logic ack);
        logic [8:0] q;
        start();
        xfer({1'b1, dev, 1'b0, 1'b1}, q);
        ack = ~q[0];
        xfer({idx, 1'b1}, q);
        if (rd) begin
            start();
            xfer({1'b1, dev, 1'b1, 1'b1}, q);
            xfer(9'h1ff, q);
        end else begin
            xfer({wd, 1'b1}, q);
        end
        rdat = q[8:1];
        #(HALF / 2) sda_out = 1'b0;
        #(HALF / 2) scl_out = 1'b1;
        #(HALF) sda_out = 1'b1;
        #(HALF);
    endtask
endmodule
`default_nettype wire
